/* File: logic/timer_pkg.sv */
package timer_pkg;
    // --------------------------------------------------------------
    // Register addresses and pages
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_RUN_CTRL  = 8'h88;
    localparam logic [7:0] ADDR_MODE_SEL  = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
    localparam logic [7:0] ADDR_AUX_CKO   = 8'hA3;
    localparam logic [7:0] ADDR_AUX_PAGED = 8'hA4;
    localparam logic [3:0] PAGE_PIN0      = 4'h0;
    localparam logic [3:0] PAGE_PIN1      = 4'h1;
    localparam logic [3:0] PAGE_GATE      = 4'h6;
    localparam logic [7:0] REG_RESET      = 8'h00;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int RC_TF1 = 7;
    localparam int RC_TR1 = 6;
    localparam int RC_TF0 = 5;
    localparam int RC_TR0 = 4;
    localparam int MS_TMR1_GATE_ENABLE = 7;
    localparam int MS_T1CT   = 6;
    localparam int MS_T1MODE = 4;
    localparam int MS_TMR0_GATE_ENABLE = 3;
    localparam int MS_T0CT   = 2;
    localparam int MS_T0MODE = 0;
    localparam int CK_TMR1_FAST_CLOCK_SELECT  = 3;
    localparam int CK_TMR0_FAST_CLOCK_SELECT  = 2;
    localparam int CK_TMR1_CLOCK_OUT_ENABLE = 1;
    localparam int CK_TMR0_CLOCK_OUT_ENABLE = 0;
    localparam int P0_T0PS   = 6;
    localparam int P0_TMR0_PRESCALE_EXTEND   = 0;
    localparam int P1_T1PS   = 4;
    localparam int GS_TMR1_GATE_EXTRA_SELECT   = 5;
    localparam int GS_TMR0_GATE_EXTRA_SELECT   = 4;
    // Readable bits of the auxiliary registers
    localparam logic [7:0] AUX_CKO_MASK  = 8'h0F;
    localparam logic [7:0] AUX_PIN0_MASK = 8'hC1;
    localparam logic [7:0] AUX_PIN1_MASK = 8'h30;
    localparam logic [7:0] AUX_GATE_MASK = 8'h30;
    // --------------------------------------------------------------
    // Modes and prescaler counts
    // --------------------------------------------------------------
    localparam logic [1:0] MODE_PWM    = 2'b00;
    localparam logic [1:0] MODE_16BIT  = 2'b01;
    localparam logic [1:0] MODE_RELOAD = 2'b10;
    localparam logic [1:0] MODE_SPLIT  = 2'b11;
    localparam logic [3:0] PRE12_LAST  = 4'hB;
    localparam logic [1:0] PRE48_LAST  = 2'h3;
    localparam logic [3:0] PRE192_LAST = 4'hF;
endpackage

/* File: logic/dual_timer_counter_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Overflow flag set by overflow/software, cleared by software/vector
// - Timer counts only while run bit set
// - Timer 1 gate needs level input and run
// - Timer 1 modes: PWM, 16-bit, reload, stopped
// - Timer 0 modes: PWM, 16-bit, reload
// - Timer 0 mode 3 splits into two bytes
// - Timer 0 gate source select pair
// - Timer 1 gate source select pair
// - Timer 1 clock source from two bits
// - Timer 0 clock source from three bits
// - Async sources synchronised, edges counted
// - Clock-output enable drives generated clock pin
// - Timer 0 pin location select
// - Timer 1 pin location select
// - Address 0xA4 decodes by page
// - Falling input edge increments one cycle later
// - Reload mode reloads low from high byte
// - Split high byte uses timer 1 run/flag
// - Clock-out: reload, 50% duty, no flag
module dual_timer_counter_regs
    import timer_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [3:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       tmr0_irq_ack,
    input  wire logic       tmr1_irq_ack,
    input  wire logic       ext_irq0_input,
    input  wire logic       ext_irq1_input,
    input  wire logic       tmr2_overflow_flag,
    input  wire logic       tmr3_overflow_flag,
    input  wire logic       keypad_interrupt,
    input  wire logic       serial1_transmit_flag,
    input  wire logic       internal_low_speed_osc,
    input  wire logic       watchdog_prescaler_tap,
    input  wire logic [3:0] tmr0_input_pin,
    input  wire logic [3:0] tmr1_input_pin,
    output logic      [3:0] tmr0_clock_out_pin,
    output logic      [3:0] tmr0_clock_out_oe,
    output logic      [3:0] tmr1_clock_out_pin,
    output logic      [3:0] tmr1_clock_out_oe,
    output logic            tmr0_pwm_out,
    output logic            tmr1_pwm_out,
    output logic            tmr0_overflow_flag,
    output logic            tmr1_overflow_flag
);
    // --------------------------------------------------------------
    // Shared arithmetic
    // --------------------------------------------------------------
    // One counting step; returns {overflow, high, low}
    function automatic logic [16:0] timer_step(input logic [1:0] mode, input logic cko,
                                               input logic tick, input logic [7:0] lo,
                                               input logic [7:0] hi);
        logic [16:0] res;
        res = {1'b0, hi, lo};
        if (tick) begin
            if (cko || mode == MODE_RELOAD) begin
                res = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
            end else if (mode == MODE_16BIT) begin
                res = {({hi, lo} == 16'hFFFF), hi + {7'h00, lo == 8'hFF}, lo + 8'h01};
            end else begin
                res = {(lo == 8'hFF), hi, lo + 8'h01};
            end
        end
        return res;
    endfunction

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [7:0] run_ctrl_reg, mode_sel_reg, aux_cko_reg;
    logic [7:0] aux_pin0_reg, aux_pin1_reg, aux_gate_reg;
    logic [7:0] t0_lo_reg, t0_hi_reg, t1_lo_reg, t1_hi_reg;
    logic [7:0] rdata_reg;
    logic       wr_rc, wr_ms, wr_t0l, wr_t0h, wr_t1l, wr_t1h;
    logic       wr_cko, wr_pin0, wr_pin1, wr_gate;

    // Address decode; paged address resolves by page, the rest on every page
    assign wr_rc   = sfr_wr && sfr_addr == ADDR_RUN_CTRL;
    assign wr_ms   = sfr_wr && sfr_addr == ADDR_MODE_SEL;
    assign wr_t0l  = sfr_wr && sfr_addr == ADDR_T0_LOW;
    assign wr_t0h  = sfr_wr && sfr_addr == ADDR_T0_HIGH;
    assign wr_t1l  = sfr_wr && sfr_addr == ADDR_T1_LOW;
    assign wr_t1h  = sfr_wr && sfr_addr == ADDR_T1_HIGH;
    assign wr_cko  = sfr_wr && sfr_addr == ADDR_AUX_CKO;
    assign wr_pin0 = sfr_wr && sfr_addr == ADDR_AUX_PAGED && sfr_page == PAGE_PIN0;
    assign wr_pin1 = sfr_wr && sfr_addr == ADDR_AUX_PAGED && sfr_page == PAGE_PIN1;
    assign wr_gate = sfr_wr && sfr_addr == ADDR_AUX_PAGED && sfr_page == PAGE_GATE;

    // Field views
    logic [1:0] t0_mode, t1_mode, t0_loc, t1_loc, t0_gsel, t1_gsel;
    logic [2:0] t0_csel;
    logic [1:0] t1_csel;
    logic       t0_cko, t1_cko, t0_split;
    assign t0_mode  = mode_sel_reg[MS_T0MODE +: 2];
    assign t1_mode  = mode_sel_reg[MS_T1MODE +: 2];
    assign t0_loc   = aux_pin0_reg[P0_T0PS +: 2];
    assign t1_loc   = aux_pin1_reg[P1_T1PS +: 2];
    assign t0_gsel  = {aux_gate_reg[GS_TMR0_GATE_EXTRA_SELECT], mode_sel_reg[MS_TMR0_GATE_ENABLE]};
    assign t1_gsel  = {aux_gate_reg[GS_TMR1_GATE_EXTRA_SELECT], mode_sel_reg[MS_TMR1_GATE_ENABLE]};
    assign t0_csel  = {aux_pin0_reg[P0_TMR0_PRESCALE_EXTEND], aux_cko_reg[CK_TMR0_FAST_CLOCK_SELECT], mode_sel_reg[MS_T0CT]};
    assign t1_csel  = {aux_cko_reg[CK_TMR1_FAST_CLOCK_SELECT], mode_sel_reg[MS_T1CT]};
    assign t0_cko   = aux_cko_reg[CK_TMR0_CLOCK_OUT_ENABLE];
    assign t1_cko   = aux_cko_reg[CK_TMR1_CLOCK_OUT_ENABLE];
    assign t0_split = t0_mode == MODE_SPLIT && !t0_cko;

    // Plain configuration registers; unused aux bits are not kept
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_sel_reg <= REG_RESET;
            aux_cko_reg  <= REG_RESET;
            aux_pin0_reg <= REG_RESET;
            aux_pin1_reg <= REG_RESET;
            aux_gate_reg <= REG_RESET;
        end else if (ce) begin
            if (wr_ms)   mode_sel_reg <= sfr_wdata;
            if (wr_cko)  aux_cko_reg  <= sfr_wdata & AUX_CKO_MASK;
            if (wr_pin0) aux_pin0_reg <= sfr_wdata & AUX_PIN0_MASK;
            if (wr_pin1) aux_pin1_reg <= sfr_wdata & AUX_PIN1_MASK;
            if (wr_gate) aux_gate_reg <= sfr_wdata & AUX_GATE_MASK;
        end
    end

    // --------------------------------------------------------------
    // Prescalers and asynchronous sources
    // --------------------------------------------------------------
    logic [3:0] pre12_cnt, pre192_cnt;
    logic [1:0] pre48_cnt;
    logic       tick12, tick48, tick192;
    assign tick12  = pre12_cnt == PRE12_LAST;
    assign tick48  = tick12 && pre48_cnt == PRE48_LAST;
    assign tick192 = tick48 && pre192_cnt[1:0] == PRE48_LAST && pre192_cnt == PRE192_LAST;

    // Free-running dividers; /192 is /12 then /16
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pre12_cnt  <= 4'h0;
            pre48_cnt  <= 2'h0;
            pre192_cnt <= 4'h0;
        end else if (ce) begin
            pre12_cnt <= tick12 ? 4'h0 : pre12_cnt + 4'h1;
            if (tick12) begin
                pre48_cnt  <= pre48_cnt + 2'h1;
                pre192_cnt <= pre192_cnt + 4'h1;
            end
        end
    end

    // Two-flop synchronisers, a third stage for the edge, then a
    // registered edge pulse so the count moves one cycle after detection.
    // Sources must stay below half the clock rate or edges are lost.
    logic [2:0] pin0_sync, pin1_sync, osc_sync;
    logic       pin0_fall_reg, pin1_fall_reg, osc_fall_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin0_sync     <= 3'h0;
            pin1_sync     <= 3'h0;
            osc_sync      <= 3'h0;
            pin0_fall_reg <= 1'b0;
            pin1_fall_reg <= 1'b0;
            osc_fall_reg  <= 1'b0;
        end else if (ce) begin
            pin0_sync     <= {pin0_sync[1:0], tmr0_input_pin[t0_loc]};
            pin1_sync     <= {pin1_sync[1:0], tmr1_input_pin[t1_loc]};
            osc_sync      <= {osc_sync[1:0], internal_low_speed_osc};
            pin0_fall_reg <= pin0_sync[2] && !pin0_sync[1];
            pin1_fall_reg <= pin1_sync[2] && !pin1_sync[1];
            osc_fall_reg  <= osc_sync[2] && !osc_sync[1];
        end
    end

    // --------------------------------------------------------------
    // Clock selection, gating and counting
    // --------------------------------------------------------------
    logic        t0_src, t1_src, t0_gate_ok, t1_gate_ok;
    logic        t0_tick, t1_tick, t0h_tick;
    logic [16:0] t0_nx, t1_nx;
    logic [8:0]  t0h_nx;
    logic        t0_ovf, t1_ovf, t0h_ovf, t1_ovf_evt;

    always_comb begin
        case (t0_csel)
            3'b000:  t0_src = tick12;
            3'b001:  t0_src = pin0_fall_reg;
            3'b010:  t0_src = 1'b1;
            3'b011:  t0_src = osc_fall_reg;
            3'b100:  t0_src = tick48;
            3'b101:  t0_src = watchdog_prescaler_tap;
            3'b110:  t0_src = tick192;
            default: t0_src = t1_ovf_evt;
        endcase
        case (t1_csel)
            2'b00:   t1_src = tick12;
            2'b01:   t1_src = pin1_fall_reg;
            2'b10:   t1_src = 1'b1;
            default: t1_src = tick48;
        endcase
        case (t0_gsel)
            2'b00:   t0_gate_ok = 1'b1;
            2'b01:   t0_gate_ok = ext_irq0_input;
            2'b10:   t0_gate_ok = tmr2_overflow_flag;
            default: t0_gate_ok = keypad_interrupt;
        endcase
        case (t1_gsel)
            2'b00:   t1_gate_ok = 1'b1;
            2'b01:   t1_gate_ok = ext_irq1_input;
            2'b10:   t1_gate_ok = tmr3_overflow_flag;
            default: t1_gate_ok = serial1_transmit_flag;
        endcase
    end

    assign t0_tick = run_ctrl_reg[RC_TR0] && t0_gate_ok && t0_src;
    // Timer 1 mode 3 holds the count as a cleared run bit would, unless timer 1 clock-out is enabled
    assign t1_tick = run_ctrl_reg[RC_TR1] && t1_gate_ok && t1_src
                     && (t1_mode != MODE_SPLIT || t1_cko);
    // Split high byte: internal clock only, under the timer 1 run bit
    assign t0h_tick = t0_split && run_ctrl_reg[RC_TR1]
                      && (aux_cko_reg[CK_TMR0_FAST_CLOCK_SELECT] || tick12);
    assign t0_nx  = timer_step(t0_split ? MODE_PWM : t0_mode, t0_cko, t0_tick,
                               t0_lo_reg, t0_hi_reg);
    assign t1_nx  = timer_step(t1_mode, t1_cko, t1_tick, t1_lo_reg, t1_hi_reg);
    assign t0h_nx = {1'b0, t0_hi_reg} + {8'h00, t0h_tick};
    assign t0_ovf = t0_nx[16];
    assign t1_ovf = t1_nx[16];
    assign t0h_ovf = t0h_nx[8];
    assign t1_ovf_evt = t1_ovf;

    // Count registers; a software write wins over counting
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t0_lo_reg <= REG_RESET;
            t0_hi_reg <= REG_RESET;
            t1_lo_reg <= REG_RESET;
            t1_hi_reg <= REG_RESET;
        end else if (ce) begin
            t0_lo_reg <= wr_t0l ? sfr_wdata : t0_nx[7:0];
            t0_hi_reg <= wr_t0h ? sfr_wdata : (t0_split ? t0h_nx[7:0] : t0_nx[15:8]);
            t1_lo_reg <= wr_t1l ? sfr_wdata : t1_nx[7:0];
            t1_hi_reg <= wr_t1h ? sfr_wdata : t1_nx[15:8];
        end
    end

    // --------------------------------------------------------------
    // Run control and overflow flags
    // --------------------------------------------------------------
    logic t0_flag_set, t1_flag_set;
    // Clock-out rollovers never raise a flag, so no interrupt follows
    assign t0_flag_set = t0_ovf && !t0_cko;
    assign t1_flag_set = t0_split ? t0h_ovf : (t1_ovf && !t1_cko);

    // Hardware set beats a software or vector clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_ctrl_reg <= REG_RESET;
        end else if (ce) begin
            if (wr_rc) begin
                run_ctrl_reg <= sfr_wdata;
            end
            if (t1_flag_set) begin
                run_ctrl_reg[RC_TF1] <= 1'b1;
            end else if (!wr_rc && tmr1_irq_ack) begin
                run_ctrl_reg[RC_TF1] <= 1'b0;
            end
            if (t0_flag_set) begin
                run_ctrl_reg[RC_TF0] <= 1'b1;
            end else if (!wr_rc && tmr0_irq_ack) begin
                run_ctrl_reg[RC_TF0] <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Clock out, PWM and read data
    // --------------------------------------------------------------
    logic       t0_cko_reg, t1_cko_reg, t0_pwm_reg, t1_pwm_reg;
    logic [3:0] t0_pin_reg, t0_oe_reg, t1_pin_reg, t1_oe_reg;

    // Toggle per overflow gives a 50% duty clock at half the overflow rate
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t0_cko_reg <= 1'b0;
            t1_cko_reg <= 1'b0;
        end else if (ce) begin
            if (t0_cko && t0_ovf) t0_cko_reg <= !t0_cko_reg;
            if (t1_cko && t1_ovf) t1_cko_reg <= !t1_cko_reg;
        end
    end

    // Routed pins are registered; one cycle behind the toggle flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t0_pin_reg <= 4'h0;
            t0_oe_reg  <= 4'h0;
            t1_pin_reg <= 4'h0;
            t1_oe_reg  <= 4'h0;
        end else if (ce) begin
            t0_oe_reg  <= {3'h0, t0_cko} << t0_loc;
            t0_pin_reg <= {3'h0, t0_cko && t0_cko_reg} << t0_loc;
            t1_oe_reg  <= {3'h0, t1_cko} << t1_loc;
            t1_pin_reg <= {3'h0, t1_cko && t1_cko_reg} << t1_loc;
        end
    end

    // PWM compare, only meaningful in mode 0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t0_pwm_reg <= 1'b0;
            t1_pwm_reg <= 1'b0;
        end else if (ce) begin
            t0_pwm_reg <= t0_mode == MODE_PWM && !t0_cko && t0_lo_reg >= t0_hi_reg;
            t1_pwm_reg <= t1_mode == MODE_PWM && !t1_cko && t1_lo_reg >= t1_hi_reg;
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads 0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= REG_RESET;
        end else if (ce && sfr_rd) begin
            case (sfr_addr)
                ADDR_RUN_CTRL: rdata_reg <= run_ctrl_reg;
                ADDR_MODE_SEL: rdata_reg <= mode_sel_reg;
                ADDR_T0_LOW:   rdata_reg <= t0_lo_reg;
                ADDR_T0_HIGH:  rdata_reg <= t0_hi_reg;
                ADDR_T1_LOW:   rdata_reg <= t1_lo_reg;
                ADDR_T1_HIGH:  rdata_reg <= t1_hi_reg;
                ADDR_AUX_CKO:  rdata_reg <= aux_cko_reg;
                ADDR_AUX_PAGED: begin
                    case (sfr_page)
                        PAGE_PIN0: rdata_reg <= aux_pin0_reg;
                        PAGE_PIN1: rdata_reg <= aux_pin1_reg;
                        PAGE_GATE: rdata_reg <= aux_gate_reg;
                        default:   rdata_reg <= REG_RESET;
                    endcase
                end
                default: rdata_reg <= REG_RESET;
            endcase
        end
    end

    assign sfr_rdata          = rdata_reg;
    assign tmr0_clock_out_pin = t0_pin_reg;
    assign tmr0_clock_out_oe  = t0_oe_reg;
    assign tmr1_clock_out_pin = t1_pin_reg;
    assign tmr1_clock_out_oe  = t1_oe_reg;
    assign tmr0_pwm_out       = t0_pwm_reg;
    assign tmr1_pwm_out       = t1_pwm_reg;
    assign tmr0_overflow_flag = run_ctrl_reg[RC_TF0];
    assign tmr1_overflow_flag = run_ctrl_reg[RC_TF1];

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);

    sequence t0_reload_wrap;
        t0_tick && t0_mode == MODE_RELOAD && t0_lo_reg == 8'hFF && !wr_t0l && !wr_t0h;
    endsequence
    sequence pin0_edge;
        pin0_sync[2] && !pin0_sync[1];
    endsequence

    flag_set_wins_a: assert property (t0_flag_set |=> tmr0_overflow_flag)
        else $error("timer 0 overflow did not set its flag");
    flag_ack_clear_a: assert property (tmr1_irq_ack && !t1_flag_set && !wr_rc
                                       |=> !tmr1_overflow_flag)
        else $error("vector ack did not clear timer 1 flag");
    run_stop_hold_a: assert property (!run_ctrl_reg[RC_TR0] && !wr_t0l && !wr_rc
                                      |=> $stable(t0_lo_reg))
        else $error("timer 0 low byte moved while stopped");
    gate1_hold_a: assert property (t1_gsel == 2'b01 && !ext_irq1_input && !wr_t1l
                                   && !wr_t1h |=> $stable({t1_hi_reg, t1_lo_reg}))
        else $error("timer 1 counted with gate input low");
    t1_mode3_hold_a: assert property (t1_mode == MODE_SPLIT && !t1_cko && !wr_t1l
                                      && !wr_t1h |=> $stable({t1_hi_reg, t1_lo_reg}))
        else $error("timer 1 counted in stopped mode");
    reload_load_a: assert property (t0_reload_wrap |=> t0_lo_reg == t0_hi_reg
                                    && $stable(t0_hi_reg))
        else $error("reload mode did not copy high byte");
    edge_count_a: assert property (pin0_edge |=> pin0_fall_reg ##1 !pin0_fall_reg)
        else $error("input edge pulse wrong");
    cko_no_flag_a: assert property (t0_cko && t0_ovf && !tmr0_overflow_flag && !wr_rc
                                    |=> !tmr0_overflow_flag
                                    && t0_cko_reg != $past(t0_cko_reg))
        else $error("clock-out overflow misbehaved");
endmodule
`default_nettype wire

/* File: testbench/dual_timer_counter_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_regs_tb;
    import timer_pkg::*;
    logic       sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d, x;
    logic [3:0] sfr_page = 4'h0, tin0 = 4'hF, tin1 = 4'hF, oe0, oe1, ck0, ck1;
    logic       ack0 = 1'b0, ack1 = 1'b0, ext0 = 1'b0, ext1 = 1'b0, osc = 1'b0;
    logic       pwm0, pwm1, flag0, flag1;
    int         bad_count = 0, cmp_count = 0, seed = 32'hB802B684;
    dual_timer_counter_regs dual_timer_counter_regs_inst (.sys_clk(sys_clk), .rst(rst),
        .ce(ce), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tmr0_irq_ack(ack0), .tmr1_irq_ack(ack1),
        .ext_irq0_input(ext0), .ext_irq1_input(ext1), .tmr2_overflow_flag(1'b0),
        .tmr3_overflow_flag(1'b0), .keypad_interrupt(1'b0), .serial1_transmit_flag(1'b0),
        .internal_low_speed_osc(osc), .watchdog_prescaler_tap(1'b0), .tmr0_input_pin(tin0),
        .tmr1_input_pin(tin1), .tmr0_clock_out_pin(ck0), .tmr0_clock_out_oe(oe0),
        .tmr1_clock_out_pin(ck1), .tmr1_clock_out_oe(oe1), .tmr0_pwm_out(pwm0),
        .tmr1_pwm_out(pwm1), .tmr0_overflow_flag(flag0), .tmr1_overflow_flag(flag1));
    // --------------------------------------------------------------
    // Clock, slow oscillator and bus tasks
    // --------------------------------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Oscillator kept well under half the system rate
    initial begin
        forever #37 osc = ~osc;
    end
    task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] v);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask
    // Read data is registered, so it is taken just after the accepting edge
    task automatic rd(input logic [7:0] a, input logic [3:0] p, output logic [7:0] v);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1 v = sfr_rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] pwm_level(input logic [7:0] lo, input logic [7:0] hi);
        return {7'h00, lo >= hi};
    endfunction
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] aa[4] = '{ADDR_AUX_CKO, ADDR_AUX_PAGED, ADDR_AUX_PAGED, ADDR_AUX_PAGED};
        logic [3:0] pp[4] = '{PAGE_PIN0, PAGE_PIN0, PAGE_PIN1, PAGE_GATE};
        logic [7:0] mm[4] = '{AUX_CKO_MASK, AUX_PIN0_MASK, AUX_PIN1_MASK, AUX_GATE_MASK};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 8'h88; a <= 8'h8D; a++) begin
            rd(a[7:0], 4'h0, d);
            chk("reset value", REG_RESET, d);
        end
        // Aux registers keep only their own bits; unmapped page 2 of 0xA4 reads zero
        for (int i = 0; i < 4; i++) begin
            rd(aa[i], pp[i], d);
            chk("aux reset", REG_RESET, d);
            wr(aa[i], pp[i], 8'hFF);
            rd(aa[i], pp[i], d);
            chk("aux mask", mm[i], d);
        end
        rd(ADDR_AUX_PAGED, 4'h2, d);
        chk("unmapped page", 8'h00, d);
        for (int i = 0; i < 4; i++) wr(aa[i], pp[i], 8'h00);
        $display("register test done");
        // Pin counter: three falling edges on the default location
        wr(ADDR_MODE_SEL, 4'h0, 8'h05);
        wr(ADDR_RUN_CTRL, 4'h0, 8'h10);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk) tin0 <= 4'hE;
            repeat (8) @(posedge sys_clk);
            tin0 <= 4'hF;
            repeat (8) @(posedge sys_clk);
        end
        rd(ADDR_T0_LOW, 4'h0, d);
        chk("pin count", 8'h03, d);
        wr(ADDR_RUN_CTRL, 4'h0, 8'h00);
        // PWM compare with random low bytes, timer stopped
        wr(ADDR_MODE_SEL, 4'h0, 8'h00);
        wr(ADDR_T0_HIGH, 4'h0, 8'h80);
        wr(ADDR_T1_HIGH, 4'h0, 8'h80);
        for (int i = 0; i < 6; i++) begin
            x = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($random(seed));
            wr(ADDR_T0_LOW, 4'h0, x);
            wr(ADDR_T1_LOW, 4'h0, x);
            repeat (3) @(posedge sys_clk);
            chk("pwm level", pwm_level(x, 8'h80), {7'h00, pwm0});
            chk("t1 pwm level", pwm_level(x, 8'h80), {7'h00, pwm1});
        end
        $display("counter and pwm test done");
        // Clock-out drive follows the enable and the pin location
        wr(ADDR_AUX_CKO, 4'h0, 8'h03);
        for (int l = 0; l < 4; l++) begin
            wr(ADDR_AUX_PAGED, PAGE_PIN0, 8'(l << 6));
            wr(ADDR_AUX_PAGED, PAGE_PIN1, 8'(l << 4));
            repeat (3) @(posedge sys_clk);
            chk("t0 drive", 8'(1 << l), {4'h0, oe0});
            chk("t1 drive", 8'(1 << l), {4'h0, oe1});
        end
        wr(ADDR_AUX_CKO, 4'h0, 8'h0C);
        repeat (3) @(posedge sys_clk);
        chk("drive off", 8'h00, {oe1, oe0});
        wr(ADDR_AUX_PAGED, PAGE_PIN0, 8'h00);
        // 16-bit rollover on the fast clock, then stop and acknowledge
        wr(ADDR_MODE_SEL, 4'h0, 8'h01);
        wr(ADDR_T0_LOW, 4'h0, 8'hFE);
        wr(ADDR_T0_HIGH, 4'h0, 8'hFF);
        wr(ADDR_RUN_CTRL, 4'h0, 8'h10);
        repeat (6) @(posedge sys_clk);
        chk("t0 flag set", 8'h01, {7'h00, flag0});
        wr(ADDR_RUN_CTRL, 4'h0, 8'h20);
        @(posedge sys_clk) ack0 <= 1'b1;
        @(posedge sys_clk) ack0 <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("t0 flag ack", 8'h00, {7'h00, flag0});
        rd(ADDR_T0_LOW, 4'h0, x);
        repeat (5) @(posedge sys_clk);
        rd(ADDR_T0_LOW, 4'h0, d);
        chk("stopped count", x, d);
        // Auto-reload keeps the high byte
        wr(ADDR_MODE_SEL, 4'h0, 8'h02);
        wr(ADDR_T0_HIGH, 4'h0, 8'hF0);
        wr(ADDR_T0_LOW, 4'h0, 8'hFE);
        wr(ADDR_RUN_CTRL, 4'h0, 8'h10);
        repeat (10) @(posedge sys_clk);
        chk("reload flag", 8'h01, {7'h00, flag0});
        wr(ADDR_RUN_CTRL, 4'h0, 8'h00);
        rd(ADDR_T0_HIGH, 4'h0, d);
        chk("reload high", 8'hF0, d);
        rd(ADDR_T0_LOW, 4'h0, d);
        // Twelve ticks from FE: one wrap to F0, then ten more
        chk("reload low", 8'hFA, d);
        $display("timer0 test done");
        // Timer 1 held by a low gate and by mode 3, then released by the gate
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_MODE_SEL, 4'h0, m == 0 ? 8'h90 : 8'h30);
            wr(ADDR_T1_LOW, 4'h0, 8'h00);
            wr(ADDR_RUN_CTRL, 4'h0, 8'h40);
            repeat (10) @(posedge sys_clk);
            rd(ADDR_T1_LOW, 4'h0, d);
            chk("t1 held", 8'h00, d);
        end
        wr(ADDR_MODE_SEL, 4'h0, 8'h90);
        @(posedge sys_clk) ext1 <= 1'b1;
        repeat (10) @(posedge sys_clk);
        wr(ADDR_RUN_CTRL, 4'h0, 8'h00);
        rd(ADDR_T1_LOW, 4'h0, d);
        chk("t1 gated run", 8'h01, {7'h00, d != 8'h00});
        // Timer 1 clock out: all-ones reload wraps each tick
        wr(ADDR_T1_HIGH, 4'h0, 8'hFF);
        wr(ADDR_T1_LOW, 4'h0, 8'hFF);
        wr(ADDR_AUX_CKO, 4'h0, 8'h0A);
        wr(ADDR_RUN_CTRL, 4'h0, 8'h40);
        repeat (4) @(posedge sys_clk);
        #1 x = {4'h0, ck1};
        @(posedge sys_clk) #1 d = {4'h0, ck1};
        chk("t1 clock toggle", 8'h08, x ^ d);
        chk("t1 cko flag", 8'h00, {7'h00, flag1});
        // Split timer 0 high byte sets the timer 1 flag
        wr(ADDR_MODE_SEL, 4'h0, 8'h03);
        wr(ADDR_AUX_CKO, 4'h0, 8'h0C);
        wr(ADDR_T0_HIGH, 4'h0, 8'hFE);
        repeat (4) @(posedge sys_clk);
        chk("split t1 flag", 8'h01, {7'h00, flag1});
        @(posedge sys_clk) ack1 <= 1'b1;
        @(posedge sys_clk) ack1 <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("t1 flag ack", 8'h00, {7'h00, flag1});
        wr(ADDR_RUN_CTRL, 4'h0, 8'h00);
        $display("timer1 test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
